// ==== pkg/eil_pkg.sv ====
package eil_pkg;
	// register byte addresses on the apb bus
	localparam logic [11:0] EIL_OFF_STATUS_CTRL = 12'h000;
	localparam logic [11:0] EIL_OFF_CONFIG_TWO = 12'h004;
	// status and control field positions
	localparam int EIL_BIT_MODE = 0;
	localparam int EIL_BIT_MASK = 1;
	localparam int EIL_BIT_ACK = 2;
	localparam int EIL_BIT_PEND = 3;
	// config register two field positions
	localparam int EIL_BIT_FUNC_EN = 0;
	// reset values
	localparam logic EIL_RST_MODE = 1'b0;
	localparam logic EIL_RST_MASK = 1'b0;
	localparam logic EIL_RST_FUNC_EN = 1'b0;
	localparam logic EIL_RST_LATCH = 1'b0;
	localparam logic EIL_RST_PIN = 1'b1;

	typedef struct packed {
		logic [11:0] paddr;
		logic pwrite;
		logic [31:0] pwdata;
	} eil_apb_req_s;

	typedef enum logic [1:0] {
		EIL_IDLE = 2'b00,
		EIL_PENDING = 2'b01,
		EIL_HELD_LOW = 2'b11
	} eil_state_e;
endpackage

// ==== hdl/eil_pin_sync.sv ====
module eil_pin_sync
	import eil_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// pin
	input wire logic pin_n,
	// synchronised level and edge
	output logic level,
	output logic fall_pulse
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// two stages; the first is read only by the second
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= EIL_RST_PIN;
			sync_reg <= EIL_RST_PIN;
			prev_reg <= EIL_RST_PIN;
		end else if (clk_en) begin
			meta_reg <= pin_n;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign fall_pulse = prev_reg & ~sync_reg;
endmodule

// ==== hdl/eil_apb_regs.sv ====
module eil_apb_regs
	import eil_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire eil_apb_req_s req,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// register controls
	input wire logic pending,
	output logic mode,
	output logic mask,
	output logic func_en,
	output logic sw_ack
);
	logic access;
	logic hit_sc;
	logic hit_cfg;
	logic [31:0] rd_next;

	assign access = psel & penable & clk_en;
	assign hit_sc = req.paddr == EIL_OFF_STATUS_CTRL;
	assign hit_cfg = req.paddr == EIL_OFF_CONFIG_TWO;
	assign pready = 1'b1;
	// unmapped addresses answer with an error, reads as zero
	assign pslverr = psel & penable & ~(hit_sc | hit_cfg);
	assign sw_ack = access & req.pwrite & hit_sc & req.pwdata[EIL_BIT_ACK];

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mode <= EIL_RST_MODE;
			mask <= EIL_RST_MASK;
			func_en <= EIL_RST_FUNC_EN;
		end else if (access & req.pwrite) begin
			if (hit_sc) begin
				mode <= req.pwdata[EIL_BIT_MODE];
				mask <= req.pwdata[EIL_BIT_MASK];
			end
			if (hit_cfg)
				func_en <= req.pwdata[EIL_BIT_FUNC_EN];
		end
	end

	always_comb begin
		rd_next = 32'h0000_0000;
		if (hit_sc) begin
			rd_next[EIL_BIT_MODE] = mode;
			rd_next[EIL_BIT_MASK] = mask;
			rd_next[EIL_BIT_PEND] = pending;
			rd_next[EIL_BIT_ACK] = 1'b0;
		end else if (hit_cfg) begin
			rd_next[EIL_BIT_FUNC_EN] = func_en;
		end
	end

	// read data registered in the setup cycle, valid through the access phase
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			prdata <= 32'h0000_0000;
		else if (clk_en & psel & ~penable)
			prdata <= rd_next;
	end
endmodule

// ==== hdl/eil_top.sv ====
// How it works
// - config enable bit zero disables interrupt function and frees pin to port.
// - a falling edge on the pin sets the request latch.
// - vector fetch acknowledge clears the latch that caused it.
// - writing one to the ack bit clears the latch.
// - any reset clears the request latch.
// - falling edge only after reset; mode bit selects edge-plus-level.
// - mask bit set keeps the request from the priority logic.
// - mode one makes falling edge and low level both triggers.
// - level mode withdraws only after pin high and an acknowledge.
// - level mode keeps the request while the pin stays low.
// - acknowledge and pin return high may come in either order.
// - a falling edge after acknowledge sets the latch again.
// - reset clears mode bit too, dropping the request with pin low.
// - mode zero: vector fetch or software ack clears latch at once.
// - pending flag readable regardless of mask bit.
// - pin level is offered to branch-on-pin instructions.
// - mask bit one disables, zero enables, read/write, resets zero.
// - logic stays active in wait mode for wakeup.
// - logic stays active in stop mode for wakeup.
//
// Our own choices: the APB slave port and the address map.
module eil_top
	import eil_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// external pin, active low
	input wire logic ext_int_n,
	// cpu side
	input wire logic vector_fetch,
	output logic cpu_irq_req,
	output logic pending_flag,
	output logic branch_if_pin_high,
	output logic branch_if_pin_low,
	output logic port_owns_pin,
	// low power, informational; logic ignores it
	input wire logic low_power
);
	eil_apb_req_s req;
	logic pin_level;
	logic pin_fall;
	logic mode;
	logic local_request_mask;
	logic ext_int_function_enable;
	logic sw_ack;
	logic ack;
	logic set_ev;
	logic latch_reg;
	logic latch_next;
	logic pin_low_q;
	logic request;
	logic branch_level_reg;
	eil_state_e state_reg;
	eil_state_e state_next;

	assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};

	eil_pin_sync u_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.pin_n(ext_int_n),
		.level(pin_level),
		.fall_pulse(pin_fall)
	);

	eil_apb_regs u_regs (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.psel(psel),
		.penable(penable),
		.req(req),
		.pready(pready),
		.pslverr(pslverr),
		.prdata(prdata),
		.pending(request),
		.mode(mode),
		.mask(local_request_mask),
		.func_en(ext_int_function_enable),
		.sw_ack(sw_ack)
	);

	// vector fetch only acknowledges while this source is the one asking
	assign ack = sw_ack | (vector_fetch & cpu_irq_req);
	assign set_ev = ext_int_function_enable & pin_fall;
	assign pin_low_q = ext_int_function_enable & mode & ~pin_level;

	// set wins over ack so an edge in the ack cycle is kept
	always_comb begin
		latch_next = latch_reg;
		if (ack)
			latch_next = 1'b0;
		if (set_ev)
			latch_next = 1'b1;
		if (!ext_int_function_enable)
			latch_next = 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			latch_reg <= EIL_RST_LATCH;
		else if (clk_en)
			latch_reg <= latch_next;
	end

	// in level mode, request drops only once latch is cleared and pin is back high, any order
	// keyed on any non-idle state so the request does not dip in the ack cycle
	assign request = latch_reg | (pin_low_q & (state_reg != EIL_IDLE));

	// tracks a level request whose latch was acknowledged while pin stays low
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			EIL_IDLE: begin
				if (latch_reg)
					state_next = EIL_PENDING;
			end
			EIL_PENDING: begin
				if (!latch_reg && pin_low_q)
					state_next = EIL_HELD_LOW;
				else if (!latch_reg)
					state_next = EIL_IDLE;
			end
			EIL_HELD_LOW: begin
				if (latch_reg)
					state_next = EIL_PENDING;
				else if (!pin_low_q)
					state_next = EIL_IDLE;
			end
			default: state_next = EIL_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			state_reg <= EIL_IDLE;
		else if (clk_en)
			state_reg <= state_next;
	end

	// no clock gating by low_power: wakeup needs the request path alive
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			cpu_irq_req <= 1'b0;
		else if (clk_en)
			cpu_irq_req <= request & ~local_request_mask;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			branch_level_reg <= EIL_RST_PIN;
		else if (clk_en)
			branch_level_reg <= pin_level;
	end

	assign pending_flag = request;
	assign branch_if_pin_high = branch_level_reg;
	assign branch_if_pin_low = ~branch_level_reg;
	assign port_owns_pin = ~ext_int_function_enable;
endmodule

// ==== sim/eil_monitor.sv ====
module eil_monitor
	import eil_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// pin and cpu
	input wire logic ext_int_n,
	input wire logic vector_fetch,
	input wire logic cpu_irq_req,
	input wire logic pending_flag,
	input wire logic branch_if_pin_high,
	input wire logic branch_if_pin_low,
	input wire logic port_owns_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_fall_sets: assert property ($fell(ext_int_n) && clk_en && !port_owns_pin
		|-> ##[2:4] pending_flag) else $error("pin fall not latched");
	a_pin_level: assert property ($fell(ext_int_n) |-> ##[2:4] branch_if_pin_low)
		else $error("pin level not shown");
	a_pin_pair: assert property (branch_if_pin_high != branch_if_pin_low)
		else $error("pin level outputs disagree");
	a_irq_cause: assert property (cpu_irq_req |-> $past(pending_flag))
		else $error("request without pending");
	a_owner_quiet: assert property (port_owns_pin[*3] |-> !pending_flag && !cpu_irq_req)
		else $error("request while function off");
	a_fetch_clears: assert property (ext_int_n[*4] ##0 (vector_fetch && cpu_irq_req)
		|=> !pending_flag) else $error("vector fetch did not clear");
	a_ack_reads0: assert property (psel && penable && !pwrite && paddr == EIL_OFF_STATUS_CTRL
		|-> !prdata[EIL_BIT_ACK]) else $error("ack bit read nonzero");
	a_err_unmapped: assert property (psel && penable
		|-> pslverr == !(paddr == EIL_OFF_STATUS_CTRL || paddr == EIL_OFF_CONFIG_TWO))
		else $error("slave error wrong");
	a_zero_wait: assert property (psel && penable |-> pready) else $error("wait state seen");
endmodule

bind eil_top eil_monitor u_eil_monitor (.ref_clk, .rstn, .clk_en, .psel, .penable, .paddr,
	.pwrite, .pready, .pslverr, .prdata, .ext_int_n, .vector_fetch, .cpu_irq_req,
	.pending_flag, .branch_if_pin_high, .branch_if_pin_low, .port_owns_pin);

// ==== sim/eil_cpu_model.sv ====
module eil_cpu_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// control
	input wire logic global_mask,
	input wire logic slow,
	// request and fetch
	input wire logic cpu_irq_req,
	output logic vector_fetch
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_reg;
	// one fetch pulse per service; slow mode delays it three cycles
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			vector_fetch <= 1'b0;
			wait_reg <= 2'h0;
		end else if (vector_fetch || !cpu_irq_req || global_mask) begin
			vector_fetch <= 1'b0;
			wait_reg <= 2'h0;
		end else if (!slow || wait_reg == 2'h3) begin
			vector_fetch <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 2'h1;
		end
	end
endmodule

// ==== sim/eil_top_tb.sv ====
module eil_top_tb
	import eil_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] S = EIL_OFF_STATUS_CTRL;
	localparam logic [31:0] MD = 32'h1 << EIL_BIT_MODE;
	localparam logic [31:0] MK = 32'h1 << EIL_BIT_MASK;
	localparam logic [31:0] AK = 32'h1 << EIL_BIT_ACK;
	localparam logic [31:0] PD = 32'h1 << EIL_BIT_PEND;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic ext_int_n = 1'b1;
	logic low_power = 1'b0;
	logic global_mask = 1'b1;
	logic slow = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, err, cpu_irq_req, pending_flag, vector_fetch;
	logic branch_if_pin_high, branch_if_pin_low, port_owns_pin;
	int n_fail = 0;
	int tests_run = 0;
	always #4 ref_clk = ~ref_clk;
	eil_top u_eil_top (.ref_clk, .rstn, .clk_en, .psel, .penable, .paddr, .pwrite,
		.pwdata, .pready, .pslverr, .prdata, .ext_int_n, .vector_fetch, .cpu_irq_req,
		.pending_flag, .branch_if_pin_high, .branch_if_pin_low, .port_owns_pin, .low_power);
	eil_cpu_model u_eil_cpu_model (.ref_clk, .rstn, .global_mask, .slow, .cpu_irq_req,
		.vector_fetch);
	task automatic tally_and_finish;
		if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			chk("pready", 32'h1, 32'h0);
			tally_and_finish();
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk("prdata", e, rdat);
	endtask
	task automatic pin(input logic v);
		ext_int_n <= v;
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic t_edge;
		apb(EIL_OFF_CONFIG_TWO, 1'b1, 32'h1 << EIL_BIT_FUNC_EN);
		pin(1'b0);
		chk("irq", 1, cpu_irq_req);
		rd(S, PD);
		apb(S, 1'b1, AK);
		chk("pend", 0, pending_flag);
		pin(1'b1);
		pin(1'b0);
		chk("pend", 1, pending_flag);
		apb(S, 1'b1, MK);
		// irq is registered: it drops one edge after the mask lands
		@(posedge ref_clk);
		chk("irq", 0, cpu_irq_req);
		rd(S, MK | PD);
		apb(S, 1'b1, MK | AK);
		pin(1'b1);
		rd(S, MK);
	endtask
	task automatic t_vector;
		apb(S, 1'b1, 32'h0);
		low_power <= 1'b1;
		pin(1'b0);
		pin(1'b1);
		chk("pend", 1, pending_flag);
		global_mask <= 1'b0;
		slow <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("pend", 0, pending_flag);
		global_mask <= 1'b1;
		low_power <= 1'b0;
	endtask
	task automatic t_level;
		apb(S, 1'b1, MD);
		pin(1'b0);
		global_mask <= 1'b0;
		// every cycle, so a one-cycle dip at the fetch ack is caught
		repeat (8) begin
			@(posedge ref_clk);
			chk("pend", 1, pending_flag);
			chk("irq", 1, cpu_irq_req);
		end
		apb(S, 1'b1, MD | MK);
		global_mask <= 1'b1;
		pin(1'b1);
		chk("pend", 0, pending_flag);
		pin(1'b0);
		pin(1'b1);
		chk("pend", 1, pending_flag);
		apb(S, 1'b1, MD | MK | AK);
		chk("pend", 0, pending_flag);
	endtask
	task automatic t_reset_mid;
		pin(1'b0);
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		chk("pend", 0, pending_flag);
		rd(S, 32'h0);
		chk("owns", 1, port_owns_pin);
		pin(1'b1);
		rd(12'h008, 32'h0);
		chk("pslverr", 1, err);
	endtask
	task automatic t_freeze;
		// a write while frozen must not land
		clk_en <= 1'b0;
		apb(S, 1'b1, MK);
		clk_en <= 1'b1;
		rd(S, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		rd(S, 32'h0);
		t_edge();
		t_vector();
		t_level();
		t_reset_mid();
		t_freeze();
		tally_and_finish();
	end
endmodule
